//--- msbs_pkg.sv
// Package for the microsequencer next-address and branch stack block.
// Assumes a single core clock; all users import msbs_pkg::*.
package msbs_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned COND_W = 8;
   localparam int unsigned STACK_DEPTH = 4;
   localparam int unsigned OP_W = 3;
   localparam int unsigned NUM_TARGETS = 4;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 8'h00;

   // Next-address operations carried by the current microword
   typedef enum logic [2:0] {
      MSBS_OP_CONT = 3'h0,
      MSBS_OP_BRANCH = 3'h1,
      MSBS_OP_PUSH = 3'h3,
      MSBS_OP_PUSH_MASK = 3'h2,
      MSBS_OP_RETURN = 3'h6
   } msbs_op_e;
endpackage : msbs_pkg

//--- msbs_stack.sv
// Last-in first-out address stack for the microsequencer.
// Assumes push and pop are never asked for in the same cycle.
module msbs_stack #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Requests
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   // State
   output logic [WIDTH-1:0] top_q,
   output logic empty_q
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   localparam int unsigned CNT_W = $clog2(DEPTH + 1);
   logic [CNT_W-1:0] cnt_q, cnt_d;

   // Entry 0 is the top; pushes shift down so the oldest falls off a full stack
   always_comb begin
      mem_d = mem_q;
      cnt_d = cnt_q;
      if (push) begin
         for (int i = DEPTH-1; i > 0; i--) begin
            mem_d[i] = mem_q[i-1];
         end
         mem_d[0] = push_data;
         if (cnt_q != CNT_W'(DEPTH)) begin
            cnt_d = cnt_q + 1'b1;
         end
      end else if (pop) begin
         for (int i = 0; i < DEPTH-1; i++) begin
            mem_d[i] = mem_q[i+1];
         end
         mem_d[DEPTH-1] = '0;
         if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         cnt_q <= cnt_d;
      end
   end

   assign top_q = mem_q[0];
   assign empty_q = (cnt_q == '0);
endmodule // msbs_stack

//--- msbs_seq.sv
// Next-address selection of a stand-alone microsequencer with branch stack.
// Assumes the microword fields and condition inputs are synchronous to
// core_clk and that external microcode memory is addressed by next_addr_q.
// The microword is expected to be registered outside, so op and its fields
// stand for a whole cycle; nothing here retimes them.
// Summary of operation
// - One of four branch targets taken per clock
// - Dispatch: push inputs, next cycle jump there
// - Masked push ANDs inputs with immediate mask
// - Input seven is MSB, input zero LSB
// - Return jumps to top-of-stack value
module msbs_seq
   import msbs_pkg::*;
#(
   parameter int unsigned ADDR_W_P = msbs_pkg::ADDR_W,
   parameter int unsigned DEPTH_P = msbs_pkg::STACK_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Current microword
   input wire logic [msbs_pkg::OP_W-1:0] op,
   input wire logic [msbs_pkg::NUM_TARGETS-1:0] branch_cond,
   input wire logic [msbs_pkg::ADDR_W-1:0] branch_target_0,
   input wire logic [msbs_pkg::ADDR_W-1:0] branch_target_1,
   input wire logic [msbs_pkg::ADDR_W-1:0] branch_target_2,
   input wire logic [msbs_pkg::ADDR_W-1:0] branch_target_3,
   input wire logic [msbs_pkg::COND_W-1:0] push_mask,
   // Condition inputs, bit 7 is cond_input_msb, bit 0 cond_input_lsb
   input wire logic [msbs_pkg::COND_W-1:0] cond_inputs,
   // Sequencer state
   output logic [msbs_pkg::ADDR_W-1:0] next_addr_q,
   output logic stack_empty_q
);
   import msbs_pkg::*;

   // Width of the shadow entry count used by the checks
   localparam int unsigned LIVE_W = $clog2(DEPTH_P + 1);

   logic [ADDR_W-1:0] addr_d;
   logic [ADDR_W-1:0] stack_top;
   logic stack_empty;
   logic do_push, do_pop;
   logic [ADDR_W-1:0] push_word;
   logic empty_q, empty_d;
   logic [LIVE_W-1:0] live_q, live_d;

   // Priority pick of four targets; the last one acts as the else arm
   function automatic logic [ADDR_W-1:0] pick_target(
      input logic [NUM_TARGETS-1:0] c,
      input logic [ADDR_W-1:0] t0, t1, t2, t3);
      if (c[0]) return t0;
      else if (c[1]) return t1;
      else if (c[2]) return t2;
      else return t3;
   endfunction

   // Bit order kept as wired: cond_inputs[7] lands in the word's MSB
   function automatic logic [ADDR_W-1:0] form_word(
      input logic [COND_W-1:0] c);
      return ADDR_W'(c);
   endfunction

   // Sequential fetch, shared by continue, pushes and unknown ops
   function automatic logic [ADDR_W-1:0] step_addr(
      input logic [ADDR_W-1:0] a);
      return a + 1'b1;
   endfunction

   // Both push flavours load the stack and fall through to the next word
   function automatic logic is_push(
      input logic [OP_W-1:0] o);
      return o == MSBS_OP_PUSH || o == MSBS_OP_PUSH_MASK;
   endfunction

   always_comb begin
      addr_d = step_addr(next_addr_q);
      do_push = 1'b0;
      do_pop = 1'b0;
      push_word = form_word(cond_inputs);
      empty_d = stack_empty;
      case (msbs_op_e'(op))
         MSBS_OP_CONT: begin
            addr_d = step_addr(next_addr_q);
         end
         MSBS_OP_BRANCH: begin
            addr_d = pick_target(branch_cond, branch_target_0,
               branch_target_1, branch_target_2, branch_target_3);
         end
         MSBS_OP_PUSH: begin
            do_push = 1'b1;
         end
         MSBS_OP_PUSH_MASK: begin
            push_word = form_word(cond_inputs & push_mask);
            do_push = 1'b1;
         end
         MSBS_OP_RETURN: begin
            addr_d = stack_top;
            do_pop = 1'b1;
         end
         default: begin
            addr_d = step_addr(next_addr_q);
         end
      endcase
   end

   msbs_stack #(
      .WIDTH(ADDR_W_P),
      .DEPTH(DEPTH_P)
   ) u_msbs_stack (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .push(do_push),
      .pop(do_pop),
      .push_data(push_word),
      .top_q(stack_top),
      .empty_q(stack_empty)
   );

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         next_addr_q <= RESET_ADDR;
         empty_q <= 1'b1;
      end else begin
         next_addr_q <= addr_d;
         empty_q <= empty_d;
      end
   end

   // Shadow count of live entries, saturating like the stack, so the
   // empty flag is cross-checked against the op stream
   always_comb begin
      live_d = live_q;
      if (do_push && live_q != LIVE_W'(DEPTH_P)) begin
         live_d = live_q + 1'b1;
      end else if (do_pop && live_q != '0) begin
         live_d = live_q - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         live_q <= '0;
      end else begin
         live_q <= live_d;
      end
   end

   // Registered copy lags the stack by one cycle; fine for a status hint
   assign stack_empty_q = empty_q;

   // Each op check judges its last op one edge after sampling it; a reset in mid-run
   // abandons attempts in flight rather than judging a cleared stack

   // Branch lands on the picked target one edge later
   a_branch_pick: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_BRANCH |=>
      next_addr_q == pick_target($past(branch_cond),
         $past(branch_target_0), $past(branch_target_1),
         $past(branch_target_2), $past(branch_target_3)))
      else $error("branch target not taken");

   // Continue fetches the following word
   a_cont_step: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_CONT |=>
      next_addr_q == step_addr($past(next_addr_q)))
      else $error("continue did not advance");

   // First dispatch cycle only stores; the address still advances
   a_push_advance: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      is_push(op) |=>
      next_addr_q == step_addr($past(next_addr_q)))
      else $error("push did not advance");

   // Second dispatch cycle jumps to the pushed inputs
   a_dispatch_two: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_PUSH ##1 op == MSBS_OP_RETURN |=>
      next_addr_q == ADDR_W'($past(cond_inputs, 2)))
      else $error("dispatch address wrong");

   // Masked push stores only the bits that the mask keeps
   a_mask_push: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_PUSH_MASK |=>
      stack_top == ADDR_W'($past(cond_inputs) & $past(push_mask)))
      else $error("masked push value wrong");

   // Masked dispatch lands on the masked value
   a_dispatch_mask: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_PUSH_MASK ##1 op == MSBS_OP_RETURN |=>
      next_addr_q == ADDR_W'($past(cond_inputs & push_mask, 2)))
      else $error("masked dispatch wrong");

   // Input seven ends in the MSB, input zero in the LSB
   a_bit_order: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_PUSH |=>
      stack_top[COND_W-1] == $past(cond_inputs[COND_W-1]) &&
      stack_top[0] == $past(cond_inputs[0]))
      else $error("pushed bit order wrong");

   // Return loads the top entry as the next address
   a_return_jump: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_RETURN |=> next_addr_q == $past(stack_top))
      else $error("return address wrong");

   // Return on an empty stack reads the cleared entry, address zero
   a_empty_pop: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      op == MSBS_OP_RETURN && stack_empty |=> next_addr_q == '0)
      else $error("empty return not zero");

   // After a return the entry below becomes the top
   a_return_pop: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      is_push(op) ##1 is_push(op) ##1 op == MSBS_OP_RETURN |=>
      stack_top == $past(push_word, 3))
      else $error("return did not pop");

   // Stack emptiness follows the shadow entry count
   a_live_empty: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      stack_empty == (live_q == '0))
      else $error("stack count disagrees");

   // Status output is the stack flag one cycle late
   a_empty_lag: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      stack_empty_q == $past(stack_empty))
      else $error("empty status lag wrong");
endmodule // msbs_seq

//--- msbs_cond_src.sv
// Model of the system logic that drives the condition inputs.
// Assumes the bench raises hold while a push samples the inputs.
module msbs_cond_src (
   // Clock
   input wire logic core_clk,
   // Bench control
   input wire logic hold,
   input wire logic [7:0] level,
   // Condition inputs
   output logic [7:0] cond_inputs
);
   logic [7:0] noise_q = 8'h5A;
   // Outside a push the inputs keep moving, so stale values never match
   always @(posedge core_clk) begin
      noise_q <= #1 noise_q + 8'h3B;
   end
   assign cond_inputs = hold ? level : noise_q;
endmodule // msbs_cond_src

//--- test_microsequencer_branch_stack.sv
// Self-checking bench for the sequencer next-address and stack logic.
// Assumes msbs_pkg, msbs_stack, msbs_seq and msbs_cond_src are compiled.
module test_microsequencer_branch_stack;
   timeunit 1ns;
   timeprecision 100ps;
   import msbs_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] op = 3'h0;
   logic [3:0] bc = 4'h0;
   logic [7:0] tg [4] = '{8'h10, 8'h27, 8'h3C, 8'h41};
   logic [7:0] mask = 8'h00;
   logic [7:0] cval = 8'h00;
   logic hold = 1'b0;
   logic [7:0] ci;
   logic [7:0] na;
   logic se;
   int error_cnt = 0;
   int samples_checked = 0;
   always #4 core_clk = ~core_clk;
   msbs_cond_src u_msbs_cond_src (.core_clk(core_clk), .hold(hold),
      .level(cval), .cond_inputs(ci));
   msbs_seq u_msbs_seq (.core_clk(core_clk), .reset_n(reset_n), .op(op),
      .branch_cond(bc), .branch_target_0(tg[0]), .branch_target_1(tg[1]),
      .branch_target_2(tg[2]), .branch_target_3(tg[3]), .push_mask(mask),
      .cond_inputs(ci), .next_addr_q(na), .stack_empty_q(se));
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   // Hold is set once per cycle, so back-to-back pushes keep it high
   task step(input logic [2:0] o);
      op = o;
      hold = (o == MSBS_OP_PUSH || o == MSBS_OP_PUSH_MASK);
      @(posedge core_clk);
      #1;
   endtask
   task push(input logic [2:0] o, input logic [7:0] m, input logic [7:0] v);
      mask = m;
      cval = v;
      step(o);
   endtask
   task t_branch;
      // Lower condition bits win; bit 3 never selects, target 3 is else
      for (int i = 0; i < 5; i++) begin
         bc = 4'hF << i;
         step(MSBS_OP_BRANCH);
         chk("branch", na, tg[i < 3 ? i : 3]);
      end
      step(MSBS_OP_CONT);
      chk("cont", na, tg[3] + 8'h01);
      // Unassigned op code behaves as continue
      step(3'h7);
      chk("spare op", na, tg[3] + 8'h02);
   endtask
   task t_dispatch;
      push(MSBS_OP_PUSH_MASK, 8'h0E, 8'hF4);
      chk("push adv", na, tg[3] + 8'h03);
      step(MSBS_OP_RETURN);
      chk("masked", na, 8'h04);
      // C1 differs from its bit reversal, so a swapped order shows
      push(MSBS_OP_PUSH, 8'h00, 8'hC1);
      step(MSBS_OP_RETURN);
      chk("order", na, 8'hC1);
   endtask
   task t_pop;
      push(MSBS_OP_PUSH, 8'h00, 8'hA5);
      push(MSBS_OP_PUSH_MASK, 8'h0F, 8'h3C);
      chk("live", {7'h00, se}, 8'h00);
      step(MSBS_OP_RETURN);
      chk("top", na, 8'h0C);
      step(MSBS_OP_RETURN);
      chk("below", na, 8'hA5);
      step(MSBS_OP_CONT);
      chk("empty", {7'h00, se}, 8'h01);
   endtask
   task t_reset;
      // Reset in mid-run must clear a stacked entry and the address
      push(MSBS_OP_PUSH, 8'h00, 8'h77);
      reset_n = 1'b0;
      @(posedge core_clk);
      #1;
      chk("mid rst addr", na, 8'h00);
      chk("mid rst empty", {7'h00, se}, 8'h01);
      reset_n = 1'b1;
      step(MSBS_OP_RETURN);
      chk("empty ret", na, 8'h00);
   endtask
   task close_out;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      error_cnt++;
      close_out;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      #1;
      chk("rst addr", na, 8'h00);
      chk("rst empty", {7'h00, se}, 8'h01);
      reset_n = 1'b1;
      t_branch;
      t_dispatch;
      t_pop;
      t_reset;
      close_out;
   end
endmodule // test_microsequencer_branch_stack
